//--- hw/css_sync_status.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module css_sync_status (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        opDone,
  input  wire logic [14:0] operCond,
  input  wire logic [14:0] quesCond,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             seqStart,
  output logic             ovlStart,
  output logic [15:0]      cmdArg,
  output logic             srqOut,
  output logic             istOut
);

  // ==========================================================================
  // State
  // ==========================================================================
  localparam int QW = css_pkg::QAW + 1;

  typedef struct packed {
    logic                      aPend;
    logic                      aWrite;
    logic [7:0]                aAddr;
    logic [31:0]               rdata;
    logic [QW-1:0]             wPtr;
    logic [QW-1:0]             rPtr;
    logic [QW-1:0]             termPtr;
    css_pkg::css_state_t       st;
    css_pkg::css_cmd_t         cur;
    logic                      ovlBusy;
    logic                      opcPend;
    logic [7:0]                sre;
    logic [7:0]                ese;
    logic [7:0]                esr;
    logic [7:0]                ppe;
    logic [7:0]                stbPrev;
    logic [15:0]               outq;
    logic                      mav;
    logic [15:0]               errq;
    logic                      errValid;
    logic [14:0]               operEv;
    logic [14:0]               operEn;
    logic [14:0]               operPtr;
    logic [14:0]               operNtr;
    logic [14:0]               operPrev;
    logic [14:0]               quesEv;
    logic [14:0]               quesEn;
    logic [14:0]               quesPtr;
    logic [14:0]               quesNtr;
    logic [14:0]               quesPrev;
    logic                      seqStart;
    logic                      ovlStart;
    logic [15:0]               cmdArg;
    logic                      srq;
    logic                      ist;
    logic                      ready;
    logic                      resp;
  } css_state_all_t;

  css_state_all_t    s_q;
  css_state_all_t    s_d;
  css_pkg::css_cmd_t memRd;
  css_pkg::css_cmd_t wrCmd;
  logic              memWr;
  logic [7:0]        stb;
  logic [14:0]       operRise;
  logic [14:0]       quesRise;
  logic              qEmpty;
  logic              qFull;
  logic              termAvail;
  logic              addrPhase;

  css_cmd_mem u_mem (
    .core_clk (core_clk),
    .wrEn     (memWr),
    .wrAddr   (s_q.wPtr[css_pkg::QAW-1:0]),
    .wrData   (wrCmd),
    .rdAddr   (s_q.rPtr[css_pkg::QAW-1:0]),
    .rdData_q (memRd)
  );

  // ==========================================================================
  // Combinational status summary
  // ==========================================================================
  always_comb begin
    addrPhase = hsel && htrans[1] && hready;
    qEmpty    = (s_q.wPtr == s_q.rPtr);
    qFull     = (s_q.wPtr[QW-1] != s_q.rPtr[QW-1]) &&
                (s_q.wPtr[QW-2:0] == s_q.rPtr[QW-2:0]);
    termAvail = (s_q.termPtr != s_q.rPtr);
    operRise  = (operCond & ~s_q.operPrev & s_q.operPtr) |
                (~operCond & s_q.operPrev & s_q.operNtr);
    quesRise  = (quesCond & ~s_q.quesPrev & s_q.quesPtr) |
                (~quesCond & s_q.quesPrev & s_q.quesNtr);
    stb                = 8'h00;
    stb[css_pkg::STB_ERRQ] = s_q.errValid;
    stb[css_pkg::STB_QUES] = |(s_q.quesEv & s_q.quesEn);
    stb[css_pkg::STB_MAV]  = s_q.mav;
    stb[css_pkg::STB_ESB]  = |(s_q.esr & s_q.ese);
    stb[css_pkg::STB_OPER] = |(s_q.operEv & s_q.operEn);
    stb[css_pkg::STB_MSS]  = |(stb & s_q.sre & 8'hBF);
    wrCmd.code = hwdata[3:0];
    wrCmd.arg  = hwdata[23:8];
    wrCmd.term = hwdata[31];
    memWr      = s_q.aPend && s_q.aWrite && (s_q.aAddr == css_pkg::ADDR_CMD) && !qFull;
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d          = s_q;
    s_d.seqStart = 1'b0;
    s_d.ovlStart = 1'b0;
    // Bus response is registered: no wait states, always OKAY
    s_d.ready    = 1'b1;
    s_d.resp     = 1'b0;
    s_d.operPrev = operCond;
    s_d.quesPrev = quesCond;
    s_d.operEv   = s_q.operEv | operRise;
    s_d.quesEv   = s_q.quesEv | quesRise;
    if (opDone) begin
      s_d.ovlBusy = 1'b0;
    end

    // Bus slave: zero wait states, data phase follows address phase
    s_d.aPend = addrPhase;
    if (addrPhase) begin
      s_d.aWrite = hwrite;
      s_d.aAddr  = haddr[7:0];
    end
    if (memWr) begin
      s_d.wPtr = s_q.wPtr + QW'(1);
      if (wrCmd.term) begin
        s_d.termPtr = s_q.wPtr + QW'(1);
      end
    end
    if (s_q.aPend && s_q.aWrite) begin
      unique case (s_q.aAddr)
        css_pkg::ADDR_SRE:      s_d.sre     = hwdata[7:0];
        css_pkg::ADDR_ESE:      s_d.ese     = hwdata[7:0];
        css_pkg::ADDR_PPE:      s_d.ppe     = hwdata[7:0];
        css_pkg::ADDR_OPER_EN:  s_d.operEn  = hwdata[14:0];
        css_pkg::ADDR_QUES_EN:  s_d.quesEn  = hwdata[14:0];
        css_pkg::ADDR_OPER_PTR: s_d.operPtr = hwdata[14:0];
        css_pkg::ADDR_OPER_NTR: s_d.operNtr = hwdata[14:0];
        css_pkg::ADDR_QUES_PTR: s_d.quesPtr = hwdata[14:0];
        css_pkg::ADDR_QUES_NTR: s_d.quesNtr = hwdata[14:0];
        default: ;
      endcase
    end
    // Read data stands for the data phase only
    s_d.rdata = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        css_pkg::ADDR_STB:      s_d.rdata[7:0]  = stb;
        css_pkg::ADDR_SRE:      s_d.rdata[7:0]  = s_q.sre;
        css_pkg::ADDR_ESR: begin
          s_d.rdata[7:0] = s_q.esr;
          s_d.esr        = 8'h00;
        end
        css_pkg::ADDR_ESE:      s_d.rdata[7:0]  = s_q.ese;
        css_pkg::ADDR_PPE:      s_d.rdata[7:0]  = s_q.ppe;
        css_pkg::ADDR_OUTQ: begin
          s_d.rdata[15:0] = s_q.outq;
          s_d.mav         = 1'b0;
        end
        css_pkg::ADDR_ERRQ: begin
          s_d.rdata[15:0] = s_q.errq;
          s_d.errValid    = 1'b0;
          s_d.errq        = 16'h0000;
        end
        css_pkg::ADDR_OPER_EV: begin
          s_d.rdata[14:0] = s_q.operEv;
          s_d.operEv      = operRise;
        end
        css_pkg::ADDR_OPER_EN:  s_d.rdata[14:0] = s_q.operEn;
        css_pkg::ADDR_QUES_EV: begin
          s_d.rdata[14:0] = s_q.quesEv;
          s_d.quesEv      = quesRise;
        end
        css_pkg::ADDR_QUES_EN:  s_d.rdata[14:0] = s_q.quesEn;
        css_pkg::ADDR_OPER_PTR: s_d.rdata[14:0] = s_q.operPtr;
        css_pkg::ADDR_OPER_NTR: s_d.rdata[14:0] = s_q.operNtr;
        css_pkg::ADDR_QUES_PTR: s_d.rdata[14:0] = s_q.quesPtr;
        css_pkg::ADDR_QUES_NTR: s_d.rdata[14:0] = s_q.quesNtr;
        css_pkg::ADDR_STATUS:
          s_d.rdata[7:0] = {qFull, qEmpty, s_q.opcPend, s_q.ovlBusy, 4'(s_q.st[5:2])};
        default: ;
      endcase
    end

    // Command sequencer
    unique case (s_q.st)
      css_pkg::ST_IDLE: begin
        if (termAvail) begin
          s_d.st = css_pkg::ST_FETCH;
        end
      end
      css_pkg::ST_FETCH: begin
        s_d.cur  = memRd;
        s_d.rPtr = s_q.rPtr + QW'(1);
        s_d.st   = css_pkg::ST_EXEC;
      end
      css_pkg::ST_EXEC: begin
        s_d.st = css_pkg::ST_IDLE;
        unique case (s_q.cur.code)
          css_pkg::CMD_SEQ: begin
            s_d.seqStart = 1'b1;
            s_d.cmdArg   = s_q.cur.arg;
            s_d.st       = css_pkg::ST_HOLD;
          end
          css_pkg::CMD_OVL: begin
            s_d.ovlStart = 1'b1;
            s_d.ovlBusy  = 1'b1;
            s_d.cmdArg   = s_q.cur.arg;
          end
          css_pkg::CMD_OPC: begin
            s_d.opcPend = 1'b1;
          end
          css_pkg::CMD_OPCQ: s_d.st = css_pkg::ST_OPCQ;
          css_pkg::CMD_WAI:  s_d.st = css_pkg::ST_WAIT;
          css_pkg::CMD_CLS: begin
            s_d.opcPend  = 1'b0;
            s_d.esr      = 8'h00;
            s_d.operEv   = operRise;
            s_d.quesEv   = quesRise;
            s_d.errValid = 1'b0;
          end
          css_pkg::CMD_QUERY: begin
            s_d.outq = s_q.cur.arg;
            s_d.mav  = 1'b1;
          end
          default: ;
        endcase
      end
      css_pkg::ST_HOLD: begin
        if (opDone) begin
          s_d.st = css_pkg::ST_IDLE;
        end
      end
      css_pkg::ST_WAIT: begin
        if (!s_q.ovlBusy || opDone) begin
          s_d.st = css_pkg::ST_IDLE;
        end
      end
      css_pkg::ST_OPCQ: begin
        if (!s_q.ovlBusy || opDone) begin
          s_d.esr[css_pkg::ESR_OPC] = 1'b1;
          s_d.outq = css_pkg::OPCQ_REPLY;
          s_d.mav  = 1'b1;
          s_d.st   = css_pkg::ST_IDLE;
        end
      end
      default: s_d.st = css_pkg::ST_IDLE;
    endcase

    // Completion query abandoned by the controller
    if (s_q.aPend && s_q.aWrite && (s_q.aAddr == css_pkg::ADDR_CMD) &&
        (hwdata[3:0] == css_pkg::CMD_ABORT) && (s_q.st == css_pkg::ST_OPCQ)) begin
      s_d.st                    = css_pkg::ST_IDLE;
      s_d.errq                  = css_pkg::ERR_INTERRUPT;
      s_d.errValid              = 1'b1;
      s_d.esr[css_pkg::ESR_QYE] = 1'b1;
    end

    // Pending completion fires once no overlapped work remains
    if (s_d.opcPend && !s_d.ovlBusy) begin
      s_d.opcPend               = 1'b0;
      s_d.esr[css_pkg::ESR_OPC] = 1'b1;
    end

    s_d.stbPrev = stb;
    s_d.srq     = |(stb & ~s_q.stbPrev & s_q.sre & 8'hBF) |
                  (s_q.srq & stb[css_pkg::STB_MSS]);
    s_d.ist     = |(stb & s_q.ppe);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q         <= '0;
      s_q.st      <= css_pkg::ST_IDLE;
      s_q.ready   <= 1'b1;
      s_q.operPtr <= css_pkg::PTR_RESET[14:0];
      s_q.quesPtr <= css_pkg::PTR_RESET[14:0];
      s_q.operNtr <= css_pkg::NTR_RESET[14:0];
      s_q.quesNtr <= css_pkg::NTR_RESET[14:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata    = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp     = s_q.resp;
  // Start pulses and argument go to the operation engine
  assign seqStart  = s_q.seqStart;
  assign ovlStart  = s_q.ovlStart;
  assign cmdArg    = s_q.cmdArg;
  assign srqOut    = s_q.srq;
  assign istOut    = s_q.ist;

endmodule

//--- hw/css_pkg.sv
package css_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_STB      = 8'h04;
  localparam logic [7:0] ADDR_SRE      = 8'h08;
  localparam logic [7:0] ADDR_ESR      = 8'h0C;
  localparam logic [7:0] ADDR_ESE      = 8'h10;
  localparam logic [7:0] ADDR_PPE      = 8'h14;
  localparam logic [7:0] ADDR_OUTQ     = 8'h18;
  localparam logic [7:0] ADDR_ERRQ     = 8'h1C;
  localparam logic [7:0] ADDR_OPER_EV  = 8'h20;
  localparam logic [7:0] ADDR_OPER_EN  = 8'h24;
  localparam logic [7:0] ADDR_QUES_EV  = 8'h28;
  localparam logic [7:0] ADDR_QUES_EN  = 8'h2C;
  localparam logic [7:0] ADDR_OPER_PTR = 8'h30;
  localparam logic [7:0] ADDR_OPER_NTR = 8'h34;
  localparam logic [7:0] ADDR_QUES_PTR = 8'h38;
  localparam logic [7:0] ADDR_QUES_NTR = 8'h3C;
  localparam logic [7:0] ADDR_STATUS   = 8'h40;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int STB_ERRQ = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_ESB  = 5;
  localparam int STB_MSS  = 6;
  localparam int STB_OPER = 7;
  localparam int ESR_OPC  = 0;
  localparam int ESR_QYE  = 2;

  localparam logic [15:0] PART_MASK  = 16'h7FFF;
  localparam logic [15:0] PTR_RESET  = 16'h7FFF;
  localparam logic [15:0] NTR_RESET  = 16'h0000;

  // ==========================================================================
  // Command codes (written to ADDR_CMD[3:0])
  // ==========================================================================
  localparam logic [3:0] CMD_SEQ   = 4'h1;
  localparam logic [3:0] CMD_OVL   = 4'h2;
  localparam logic [3:0] CMD_OPC   = 4'h3;
  localparam logic [3:0] CMD_OPCQ  = 4'h4;
  localparam logic [3:0] CMD_WAI   = 4'h5;
  localparam logic [3:0] CMD_CLS   = 4'h6;
  localparam logic [3:0] CMD_QUERY = 4'h7;
  localparam logic [3:0] CMD_ABORT = 4'h8;

  localparam logic [15:0] OPCQ_REPLY    = 16'h0001;
  localparam logic [15:0] ERR_INTERRUPT = 16'hFE66;
  localparam int          QDEPTH        = 8;
  localparam int          QAW           = 3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [3:0]  code;
    logic [15:0] arg;
    logic        term;
  } css_cmd_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic [31:0] hwdata;
  } css_ahb_req_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_EXEC  = 6'b000100,
    ST_WAIT  = 6'b001000,
    ST_OPCQ  = 6'b010000,
    ST_HOLD  = 6'b100000
  } css_state_t;

endpackage

//--- hw/css_cmd_mem.sv
`timescale 1ns/1ps
module css_cmd_mem (
  input  wire logic                   core_clk,
  input  wire logic                   wrEn,
  input  wire logic [css_pkg::QAW-1:0] wrAddr,
  input  wire css_pkg::css_cmd_t      wrData,
  input  wire logic [css_pkg::QAW-1:0] rdAddr,
  output css_pkg::css_cmd_t           rdData_q
);

  css_pkg::css_cmd_t mem [css_pkg::QDEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData_q <= mem[rdAddr];
  end

endmodule

//--- test/css_sync_status_asserts.sv
`timescale 1ns/1ps
module css_sync_status_asserts (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        opDone,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        seqStart,
  input wire logic        ovlStart,
  input wire logic [15:0] cmdArg
);
  logic       seqBusy_q;
  logic       rdPhase_q;
  logic [7:0] rdAddr_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqBusy_q <= 1'b0;
      rdPhase_q <= 1'b0;
      rdAddr_q  <= 8'h00;
    end else begin
      seqBusy_q <= seqStart | (seqBusy_q & ~opDone);
      rdPhase_q <= hsel & htrans[1] & hready & ~hwrite;
      rdAddr_q  <= haddr[7:0];
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_seq_order; seqBusy_q |-> !seqStart && !ovlStart; endproperty
  a_seq_order: assert property (p_seq_order) else $error("start while busy");
  property p_seq_pulse; seqStart |=> !seqStart; endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("seq start too long");
  property p_ovl_pulse; ovlStart |=> !ovlStart; endproperty
  a_ovl_pulse: assert property (p_ovl_pulse) else $error("ovl start too long");
  property p_rd_idle; !rdPhase_q |-> hrdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside phase");
  property p_part_msb;
    rdPhase_q && rdAddr_q >= css_pkg::ADDR_OPER_EV && rdAddr_q <= css_pkg::ADDR_QUES_NTR
      |-> hrdata[31:15] == 17'h0;
  endproperty
  a_part_msb: assert property (p_part_msb) else $error("part msb set");
  property p_arg_hold; $changed(cmdArg) |-> seqStart || ovlStart; endproperty
  a_arg_hold: assert property (p_arg_hold) else $error("arg changed alone");
  property p_ready; hreadyout ##1 hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("ready low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
endmodule

bind css_sync_status css_sync_status_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .opDone(opDone), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .seqStart(seqStart), .ovlStart(ovlStart), .cmdArg(cmdArg));

//--- test/css_op_model.sv
`timescale 1ns/1ps
module css_op_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        seqStart,
  input  wire logic        ovlStart,
  input  wire logic [15:0] lat,
  output logic             opDone
);
  logic [15:0] cnt_q;

  // Each started operation ends lat cycles later, like a running sweep
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_q  <= 16'h0;
      opDone <= 1'b0;
    end else begin
      opDone <= (cnt_q == 16'h1);
      if (seqStart || ovlStart) begin
        cnt_q <= lat;
      end else if (cnt_q != 16'h0) begin
        cnt_q <= cnt_q - 16'h1;
      end
    end
  end
endmodule

//--- test/css_sync_status_tb.sv
`timescale 1ns/1ps
module css_sync_status_tb;
  logic        core_clk;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        opDone;
  logic [14:0] operCond;
  logic [14:0] quesCond;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        seqStart;
  logic        ovlStart;
  logic [15:0] cmdArg;
  logic        srqOut;
  logic        istOut;
  logic [15:0] lat;
  logic [31:0] rd;
  int          fail_count;
  int          comparisons;

  css_sync_status uut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .opDone(opDone), .operCond(operCond), .quesCond(quesCond), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .seqStart(seqStart), .ovlStart(ovlStart),
    .cmdArg(cmdArg), .srqOut(srqOut), .istOut(istOut));
  css_op_model partner (.core_clk(core_clk), .reset(reset), .seqStart(seqStart),
    .ovlStart(ovlStart), .lat(lat), .opDone(opDone));

  // ==========================================================================
  // Bus and check helpers
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      fail_count++;
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    waitRdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    rd = rd & m;
  endtask

  task automatic cmd(input logic [3:0] c, input logic [15:0] a);
    wr(css_pkg::ADDR_CMD, {1'b1, 7'h0, a, 4'h0, c});
  endtask

  task automatic waitDone;
    int n;
    n = 0;
    while (opDone !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (opDone !== 1'b1) begin
      fail_count++;
    end
    repeat (12) @(posedge core_clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    rdm(css_pkg::ADDR_STB, '1);
    chk("stb", rd, 32'h0);
    rdm(css_pkg::ADDR_OPER_PTR, '1);
    chk("ptr", rd, 32'h7FFF);
    rdm(css_pkg::ADDR_QUES_NTR, '1);
    chk("ntr", rd, 32'h0);
    rdm(8'h50, '1);
    chk("unmapped", rd, 32'h0);
    rdm(css_pkg::ADDR_STATUS, 32'h40);
    chk("empty", rd, 32'h40);
  endtask

  task automatic t_seq;
    lat <= 16'd20;
    cmd(css_pkg::CMD_SEQ, 16'h1234);
    cmd(css_pkg::CMD_QUERY, 16'h0055);
    repeat (6) @(posedge core_clk);
    chk("arg", {16'h0, cmdArg}, 32'h1234);
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("mav busy", rd, 32'h0);
    waitDone;
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("mav", rd, 32'h10);
    rdm(css_pkg::ADDR_OUTQ, '1);
    chk("outq", rd, 32'h55);
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("mav read", rd, 32'h0);
  endtask

  task automatic t_ovl;
    lat <= 16'd40;
    wr(css_pkg::ADDR_ESE, 32'h1);
    wr(css_pkg::ADDR_SRE, 32'h20);
    cmd(css_pkg::CMD_OVL, 16'h0);
    cmd(css_pkg::CMD_QUERY, 16'h0066);
    cmd(css_pkg::CMD_OPC, 16'h0);
    repeat (10) @(posedge core_clk);
    rdm(css_pkg::ADDR_OUTQ, '1);
    chk("outq ovl", rd, 32'h66);
    rdm(css_pkg::ADDR_STATUS, 32'h20);
    chk("opc pend", rd, 32'h20);
    chk("srq early", {31'h0, srqOut}, 32'h0);
    waitDone;
    chk("srq", {31'h0, srqOut}, 32'h1);
    rdm(css_pkg::ADDR_STB, 32'h20);
    chk("esb", rd, 32'h20);
    rdm(css_pkg::ADDR_ESR, '1);
    chk("esr", rd, 32'h1);
    rdm(css_pkg::ADDR_ESR, '1);
    chk("esr clr", rd, 32'h0);
  endtask

  task automatic t_wai;
    cmd(css_pkg::CMD_OVL, 16'h0);
    cmd(css_pkg::CMD_WAI, 16'h0);
    cmd(css_pkg::CMD_QUERY, 16'h0077);
    repeat (10) @(posedge core_clk);
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("wai mav", rd, 32'h0);
    waitDone;
    rdm(css_pkg::ADDR_OUTQ, '1);
    chk("wai outq", rd, 32'h77);
  endtask

  task automatic t_opcq;
    cmd(css_pkg::CMD_OVL, 16'h0);
    cmd(css_pkg::CMD_OPCQ, 16'h0);
    repeat (10) @(posedge core_clk);
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("opcq mav", rd, 32'h0);
    waitDone;
    rdm(css_pkg::ADDR_OUTQ, '1);
    chk("opcq", rd, {16'h0, css_pkg::OPCQ_REPLY});
    cmd(css_pkg::CMD_OVL, 16'h0);
    cmd(css_pkg::CMD_OPCQ, 16'h0);
    repeat (8) @(posedge core_clk);
    cmd(css_pkg::CMD_ABORT, 16'h0);
    rdm(css_pkg::ADDR_STB, 32'h4);
    chk("errq flag", rd, 32'h4);
    rdm(css_pkg::ADDR_ERRQ, '1);
    chk("errq", rd, {16'h0, css_pkg::ERR_INTERRUPT});
    rdm(css_pkg::ADDR_ESR, 32'h4);
    chk("qye", rd, 32'h4);
    waitDone;
    rdm(css_pkg::ADDR_STB, 32'h10);
    chk("abort mav", rd, 32'h0);
  endtask

  task automatic t_cls;
    cmd(css_pkg::CMD_OVL, 16'h0);
    cmd(css_pkg::CMD_OPC, 16'h0);
    cmd(css_pkg::CMD_CLS, 16'h0);
    waitDone;
    rdm(css_pkg::ADDR_ESR, 32'h1);
    chk("ocis", rd, 32'h0);
    cmd(css_pkg::CMD_OPC, 16'h0);
    repeat (8) @(posedge core_clk);
    rdm(css_pkg::ADDR_ESR, 32'h1);
    chk("opc idle", rd, 32'h1);
  endtask

  task automatic t_ist;
    wr(css_pkg::ADDR_PPE, 32'h10);
    wr(css_pkg::ADDR_SRE, 32'h10);
    cmd(css_pkg::CMD_QUERY, 16'h0005);
    repeat (8) @(posedge core_clk);
    chk("ist", {31'h0, istOut}, 32'h1);
    chk("srq mav", {31'h0, srqOut}, 32'h1);
    rdm(css_pkg::ADDR_OUTQ, '1);
    repeat (2) @(posedge core_clk);
    chk("ist off", {31'h0, istOut}, 32'h0);
  endtask

  task automatic t_ev;
    wr(css_pkg::ADDR_QUES_EN, 32'h4000);
    quesCond <= 15'h4000;
    operCond <= 15'h0001;
    repeat (4) @(posedge core_clk);
    rdm(css_pkg::ADDR_STB, 32'h8);
    chk("ques sum", rd, 32'h8);
    rdm(css_pkg::ADDR_QUES_EV, '1);
    chk("ques ev", rd, 32'h4000);
    rdm(css_pkg::ADDR_QUES_EV, '1);
    chk("ques clr", rd, 32'h0);
    rdm(css_pkg::ADDR_OPER_EV, '1);
    chk("oper ev", rd, 32'h1);
    wr(css_pkg::ADDR_OPER_EN, 32'hFFFF);
    rdm(css_pkg::ADDR_OPER_EN, '1);
    chk("oper en", rd, 32'h7FFF);
    operCond <= 15'h0002;
    repeat (4) @(posedge core_clk);
    rdm(css_pkg::ADDR_STB, 32'h80);
    chk("oper sum", rd, 32'h80);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    results;
  end

  initial begin
    fail_count  = 0;
    comparisons = 0;
    reset    = 1'b1;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hsize    = 3'h0;
    hwdata   = 32'h0;
    operCond = 15'h0;
    quesCond = 15'h0;
    lat      = 16'd20;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t_reset;
    t_seq;
    t_ovl;
    t_wai;
    t_opcq;
    t_cls;
    t_ist;
    t_ev;
    results;
  end
endmodule
